// ==== design/sfpe_device.sv ====
// flash device end: command decoder, buffer, array and sequencer
// assumes link pins from outside the ref_clk domain; samples them twice
`timescale 1ns/100ps
`default_nettype none
`include "sfpe_regs.svh"
module sfpe_device import sfpe_pkg::*; #(
  parameter int PAGES = 512,
  parameter int PAGE_BYTES = 264,
  parameter int TW = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic binaryPages,
  sfpe_link_if.device link,
  input wire logic [8:0] peekPage,
  input wire logic [8:0] peekByte,
  output logic [7:0] peekData,
  output logic busyOut
);
  localparam int AW = $clog2(PAGES * PAGE_BYTES);
  localparam logic [TW-1:0] T_EP = TW'(`SFPE_ERASE_PROGRAM_TIME_US * `SFPE_CLK_MHZ);
  localparam logic [TW-1:0] T_P = TW'(`SFPE_PROGRAM_TIME_US * `SFPE_CLK_MHZ);
  localparam logic [TW-1:0] T_PE = TW'(`SFPE_PAGE_ERASE_TIME_US * `SFPE_CLK_MHZ);
  localparam logic [TW-1:0] T_BE = TW'(`SFPE_BLOCK_ERASE_TIME_US * `SFPE_CLK_MHZ);
  localparam logic [TW-1:0] T_SE = TW'(`SFPE_SECTOR_ERASE_TIME_US * `SFPE_CLK_MHZ);

  // ==========================================
  // pin synchronisers
  logic [1:0] csSync_q, clkSync_q, siSync_q;
  logic clkPrev_q, csPrev_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      csSync_q <= 2'h3;
      clkSync_q <= 2'h0;
      siSync_q <= 2'h0;
      clkPrev_q <= 1'b0;
      csPrev_q <= 1'b1;
    end else begin
      csSync_q <= {csSync_q[0], link.chipSelectN};
      clkSync_q <= {clkSync_q[0], link.serialClk};
      siSync_q <= {siSync_q[0], link.serialIn};
      clkPrev_q <= clkSync_q[1];
      csPrev_q <= csSync_q[1];
    end
  end
  logic sckRise, csRise, selected;
  assign sckRise = clkSync_q[1] & ~clkPrev_q & ~csSync_q[1];
  assign csRise = csSync_q[1] & ~csPrev_q;
  assign selected = ~csSync_q[1];

  // ==========================================
  // shifter and byte counter
  logic [2:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [2:0] byteCnt_q;
  logic [7:0] opcode_q;
  logic [23:0] addr_q;
  logic [7:0] nextByte;
  logic byteDone;
  assign nextByte = {shift_q[6:0], siSync_q[1]};
  assign byteDone = sckRise && bitCnt_q == 3'h7;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bitCnt_q <= 3'h0;
      shift_q <= 8'h00;
      byteCnt_q <= 3'h0;
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
    end else if (!selected) begin
      bitCnt_q <= 3'h0;
      byteCnt_q <= 3'h0;
    end else if (sckRise) begin
      shift_q <= nextByte;
      bitCnt_q <= bitCnt_q + 3'h1;
      if (byteDone) begin
        if (byteCnt_q == 3'h0) opcode_q <= nextByte;
        else if (byteCnt_q < 3'h4) addr_q <= {addr_q[15:0], nextByte};
        if (byteCnt_q < 3'h4) byteCnt_q <= byteCnt_q + 3'h1;
      end
    end
  end

  // ==========================================
  // address fields per page mode
  function automatic logic [8:0] pageOf(input logic [23:0] a, input logic bin);
    pageOf = bin ? a[16:8] : a[17:9];
  endfunction
  function automatic logic knownOp(input logic [7:0] op);
    case (op)
      `SFPE_OP_PGM_ERASE, `SFPE_OP_PGM_NOERASE, `SFPE_OP_PAGE_ERASE: knownOp = 1'b1;
      `SFPE_OP_BLOCK_ERASE, `SFPE_OP_SECTOR_ERASE: knownOp = 1'b1;
      default: knownOp = 1'b0;
    endcase
  endfunction

  // ==========================================
  // buffer and array storage
  logic [7:0] buffer_q [PAGE_BYTES];
  logic [7:0] array_q [PAGES * PAGE_BYTES];
  logic [8:0] bufIdx_q;
  logic [8:0] bufLen;
  assign bufLen = binaryPages ? 9'd256 : 9'd264;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bufIdx_q <= 9'h000;
    end else if (byteDone && byteCnt_q == 3'h3 && opcode_q == `SFPE_OP_LOAD) begin
      bufIdx_q <= binaryPages ? {1'b0, nextByte} : {addr_q[0], nextByte};
    end else if (byteDone && byteCnt_q == 3'h4 && opcode_q == `SFPE_OP_LOAD) begin
      bufIdx_q <= (bufIdx_q + 9'h1 >= bufLen) ? 9'h000 : bufIdx_q + 9'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (byteDone && byteCnt_q == 3'h4 && opcode_q == `SFPE_OP_LOAD) begin
      buffer_q[bufIdx_q] <= nextByte;
    end
  end

  // ==========================================
  // sequencer
  sfpe_state_t state_q;
  sfpe_cmd_t cmd_q;
  logic [8:0] first_q, last_q;
  logic timerLoad;
  logic [TW-1:0] timerCount;
  logic timerDone;
  logic [8:0] cmdPage;
  logic valid;
  assign cmdPage = pageOf(addr_q, binaryPages);
  assign valid = csRise && byteCnt_q == 3'h4;
  // unknown opcodes and loads never start the timer or raise busy
  assign timerLoad = valid && state_q == SFPE_ST_IDLE && knownOp(opcode_q);
  always_comb begin
    case (opcode_q)
      `SFPE_OP_PGM_ERASE: timerCount = T_EP;
      `SFPE_OP_PGM_NOERASE: timerCount = T_P;
      `SFPE_OP_BLOCK_ERASE: timerCount = T_BE;
      `SFPE_OP_SECTOR_ERASE: timerCount = T_SE;
      default: timerCount = T_PE;
    endcase
  end
  sfpe_timer #(.W(TW)) u_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .load(timerLoad),
    .count(timerCount),
    .done(timerDone)
  );
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SFPE_ST_IDLE;
      cmd_q <= SFPE_CMD_NONE;
      first_q <= 9'h000;
      last_q <= 9'h000;
    end else begin
      case (state_q)
        SFPE_ST_IDLE: begin
          if (timerLoad) begin
            state_q <= SFPE_ST_ERASE;
            first_q <= cmdPage;
            last_q <= cmdPage;
            case (opcode_q)
              `SFPE_OP_PGM_ERASE: cmd_q <= SFPE_CMD_PGM_ERASE;
              `SFPE_OP_PGM_NOERASE: begin
                cmd_q <= SFPE_CMD_PGM_NOERASE;
                state_q <= SFPE_ST_PROGRAM;
              end
              `SFPE_OP_PAGE_ERASE: cmd_q <= SFPE_CMD_PAGE_ERASE;
              `SFPE_OP_BLOCK_ERASE: begin
                cmd_q <= SFPE_CMD_BLOCK_ERASE;
                first_q <= {cmdPage[8:3], 3'h0};
                last_q <= {cmdPage[8:3], 3'h7};
              end
              `SFPE_OP_SECTOR_ERASE: begin
                cmd_q <= SFPE_CMD_SECTOR_ERASE;
                if (cmdPage[8:4] == 5'h00) begin
                  first_q <= {5'h00, cmdPage[3], 3'h0};
                  last_q <= {5'h00, cmdPage[3], 3'h7};
                end else if (!cmdPage[8]) begin
                  first_q <= 9'h010;
                  last_q <= 9'h0ff;
                end else begin
                  first_q <= {cmdPage[8:7], 7'h00};
                  last_q <= {cmdPage[8:7], 7'h7f};
                end
              end
              default: state_q <= SFPE_ST_IDLE;
            endcase
          end
        end
        SFPE_ST_ERASE: if (timerDone) state_q <= cmd_q == SFPE_CMD_PGM_ERASE ?
                                                   SFPE_ST_PROGRAM : SFPE_ST_IDLE;
        SFPE_ST_PROGRAM: begin
          if (cmd_q == SFPE_CMD_PGM_ERASE || timerDone) state_q <= SFPE_ST_IDLE;
        end
        default: state_q <= SFPE_ST_IDLE;
      endcase
    end
  end

  // array update at completion; erase all ones, program copies buffer
  always_ff @(posedge ref_clk) begin
    if (state_q == SFPE_ST_ERASE && timerDone) begin
      for (int p = 0; p < PAGES; p++) begin
        if (p[8:0] >= first_q && p[8:0] <= last_q) begin
          for (int b = 0; b < PAGE_BYTES; b++) array_q[p * PAGE_BYTES + b] <= 8'hff;
        end
      end
    end
    if ((state_q == SFPE_ST_PROGRAM && cmd_q == SFPE_CMD_PGM_NOERASE && timerDone) ||
        (state_q == SFPE_ST_PROGRAM && cmd_q == SFPE_CMD_PGM_ERASE)) begin
      for (int b = 0; b < PAGE_BYTES; b++) begin
        array_q[int'(first_q) * PAGE_BYTES + b] <= buffer_q[b];
      end
    end
  end

  // ==========================================
  // busy and peek outputs
  logic busyD;
  assign busyD = timerLoad ||
                 (state_q == SFPE_ST_ERASE && !(timerDone && cmd_q != SFPE_CMD_PGM_ERASE)) ||
                 (state_q == SFPE_ST_PROGRAM && cmd_q == SFPE_CMD_PGM_NOERASE && !timerDone);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busyOut <= 1'b0;
      peekData <= 8'h00;
    end else begin
      busyOut <= busyD;
      peekData <= array_q[int'(peekPage) * PAGE_BYTES + int'(peekByte)];
    end
  end
  assign link.busy = busyOut;
endmodule
`default_nettype wire

// ==== design/sfpe_host.sv ====
// host master end: sends one command frame per request
// assumes request only while ready; data bytes for loads come per dataReq
`timescale 1ns/100ps
`default_nettype none
`include "sfpe_regs.svh"
module sfpe_host import sfpe_pkg::*; (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [23:0] addr,
  input wire logic [8:0] dataCount,
  input wire logic [7:0] dataByte,
  output logic dataReq,
  output logic ready,
  output logic devBusy,
  sfpe_link_if.host link
);
  logic [1:0] busySync_q;
  logic [7:0] shift_q;
  logic [2:0] bitCnt_q;
  logic [9:0] bytesLeft_q;
  logic [3:0] div_q;
  logic [1:0] byteNo_q;
  logic csN_q, sck_q, active_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busySync_q <= 2'h0;
      devBusy <= 1'b0;
    end else begin
      busySync_q <= {busySync_q[0], link.busy};
      devBusy <= busySync_q[1];
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      csN_q <= 1'b1;
      sck_q <= 1'b0;
      active_q <= 1'b0;
      shift_q <= 8'h00;
      bitCnt_q <= 3'h0;
      bytesLeft_q <= 10'h000;
      div_q <= 4'h0;
      byteNo_q <= 2'h0;
      dataReq <= 1'b0;
      ready <= 1'b0;
    end else begin
      dataReq <= 1'b0;
      ready <= !active_q && !start && !devBusy;
      if (!active_q) begin
        if (start && !devBusy) begin
          active_q <= 1'b1;
          csN_q <= 1'b0;
          shift_q <= opcode;
          bitCnt_q <= 3'h0;
          // bytes still to follow the opcode
          bytesLeft_q <= 10'd3 + {1'b0, dataCount};
          byteNo_q <= 2'h0;
          div_q <= 4'h0;
        end
      end else if (div_q == 4'(`SFPE_LINK_HALF)) begin
        div_q <= 4'h0;
        sck_q <= ~sck_q;
        if (sck_q) begin
          shift_q <= {shift_q[6:0], 1'b0};
          bitCnt_q <= bitCnt_q + 3'h1;
          if (bitCnt_q == 3'h7) begin
            if (bytesLeft_q == 10'h000) begin
              active_q <= 1'b0;
              csN_q <= 1'b1;
            end else begin
              bytesLeft_q <= bytesLeft_q - 10'h1;
              dataReq <= byteNo_q == 2'h3;
              if (byteNo_q != 2'h3) byteNo_q <= byteNo_q + 2'h1;
              case (byteNo_q)
                2'h0: shift_q <= addr[23:16];
                2'h1: shift_q <= addr[15:8];
                2'h2: shift_q <= addr[7:0];
                default: shift_q <= dataByte;
              endcase
            end
          end
        end
      end else begin
        div_q <= div_q + 4'h1;
      end
    end
  end
  assign link.chipSelectN = csN_q;
  assign link.serialClk = sck_q;
  assign link.serialIn = shift_q[7];
endmodule
`default_nettype wire

// ==== design/sfpe_timer.sv ====
// down counter for self-timed operations
// assumes a load pulse while idle
`timescale 1ns/100ps
`default_nettype none
module sfpe_timer #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cnt_q;
  logic run_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_q <= count;
        run_q <= 1'b1;
      end else if (run_q) begin
        // two early: done and busy registers each add a cycle after this
        if (cnt_q <= W'(2)) begin
          run_q <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== shared/sfpe_link_if.sv ====
// serial link between host master and flash device, plus busy line
// assumes both ends run on ref_clk and the device samples the link clock
`timescale 1ns/100ps
`default_nettype none
interface sfpe_link_if;
  logic chipSelectN;
  logic serialClk;
  logic serialIn;
  logic busy;
  modport device (input chipSelectN, input serialClk, input serialIn, output busy);
  modport host (output chipSelectN, output serialClk, output serialIn, input busy);
endinterface
`default_nettype wire

// ==== shared/sfpe_pkg.sv ====
// types shared by both ends of the program/erase link
package sfpe_pkg;
  typedef enum logic [2:0] {
    SFPE_CMD_NONE = 3'h0,
    SFPE_CMD_LOAD = 3'h1,
    SFPE_CMD_PGM_ERASE = 3'h2,
    SFPE_CMD_PGM_NOERASE = 3'h3,
    SFPE_CMD_PAGE_ERASE = 3'h4,
    SFPE_CMD_BLOCK_ERASE = 3'h5,
    SFPE_CMD_SECTOR_ERASE = 3'h6
  } sfpe_cmd_t;
  typedef enum logic [1:0] {
    SFPE_ST_IDLE = 2'b00,
    SFPE_ST_ERASE = 2'b01,
    SFPE_ST_PROGRAM = 2'b11
  } sfpe_state_t;
endpackage

// ==== shared/sfpe_regs.svh ====
// timing counts and command codes for the program/erase sequencer
// assumes a 125 MHz ref_clk; times are in microseconds
`ifndef SFPE_REGS_SVH
`define SFPE_REGS_SVH
`define SFPE_CLK_MHZ 125
`define SFPE_OP_LOAD 8'h84
`define SFPE_OP_PGM_ERASE 8'h83
`define SFPE_OP_PGM_NOERASE 8'h88
`define SFPE_OP_PAGE_ERASE 8'h81
`define SFPE_OP_BLOCK_ERASE 8'h50
`define SFPE_OP_SECTOR_ERASE 8'h7c
`define SFPE_ERASE_PROGRAM_TIME_US 40
`define SFPE_PROGRAM_TIME_US 20
`define SFPE_PAGE_ERASE_TIME_US 20
`define SFPE_BLOCK_ERASE_TIME_US 30
`define SFPE_SECTOR_ERASE_TIME_US 50
`define SFPE_LINK_HALF 5
`endif

// ==== verif/serial_flash_program_erase_tb.sv ====
// bench: host and device joined on one link, array peeked back
// assumes the design's own timing counts; run stays under 100k cycles
`timescale 1ns/100ps
`default_nettype none
`include "sfpe_regs.svh"
module serial_flash_program_erase_tb;
  import sfpe_pkg::*;
  localparam int K = `SFPE_CLK_MHZ;
  logic ref_clk, nrst, binaryPages, start, dataReq, ready, devBusy, busyOut, stb;
  logic [7:0] opcode, dataByte, peekData;
  logic [23:0] addr;
  logic [8:0] dataCount, peekPage, peekByte;
  logic [31:0] rng;
  logic [7:0] expQ[$], dataQ[$], b[4];
  int n_fail, total_checks, m, pg, ix, sh, sp, i, sz;
  sfpe_link_if link();
  sfpe_device i_sfpe_device (.ref_clk, .nrst, .binaryPages, .link(link.device),
    .peekPage, .peekByte, .peekData, .busyOut);
  sfpe_host i_sfpe_host (.ref_clk, .nrst, .start, .opcode, .addr, .dataCount,
    .dataByte, .dataReq, .ready, .devBusy, .link(link.host));
  sfpe_link_asserts i_sfpe_link_asserts (.ref_clk, .nrst,
    .chipSelectN(link.chipSelectN), .serialClk(link.serialClk),
    .serialIn(link.serialIn), .busy(link.busy));
  // ====
  // clock, helpers
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wt(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k >= lim) begin
      n_fail++;
      $display("[FAIL] wait expected %0h seen %0h", v, s);
      results();
    end
  endtask
  // busy length bound passed in cycles; zero means no self-timed step
  task automatic cmd(input logic [7:0] op, input int a, input int n, input int tmax);
    int k;
    wt(ready, 1'b1, 20000, k);
    opcode = op;
    addr = a[23:0];
    dataCount = n[8:0];
    dataByte = n > 0 ? dataQ.pop_front() : 8'h00;
    start = 1'b1;
    @(posedge ref_clk);
    #1;
    start = 1'b0;
    if (tmax == 0) return;
    wt(busyOut, 1'b1, 3000, k);
    wt(busyOut, 1'b0, 12000, k);
    ck("busyLen", 32'h1, {31'h0, k > 0 && k <= tmax});
  endtask
  task automatic pk(input int p, input int bi, input logic [7:0] e);
    peekPage = p[8:0];
    peekByte = bi[8:0];
    expQ.push_back(e);
    @(posedge ref_clk);
    #1;
    stb = 1'b1;
    @(posedge ref_clk);
    #1;
    stb = 1'b0;
  endtask
  // ====
  // data feed and result monitor
  always @(posedge ref_clk) begin
    if (dataReq === 1'b1 && dataQ.size() > 0) dataByte <= dataQ.pop_front();
  end
  always @(posedge ref_clk) begin
    if (stb === 1'b1) ck("peekData", {24'h0, expQ.pop_front()}, {24'h0, peekData});
  end
  // ====
  // main sequence
  initial begin
    rng = 32'd90296;
    n_fail = 0;
    total_checks = 0;
    nrst = 1'b0;
    binaryPages = 1'b0;
    start = 1'b0;
    stb = 1'b0;
    opcode = 8'h00;
    addr = 24'h0;
    dataCount = 9'h0;
    dataByte = 8'h00;
    peekPage = 9'h0;
    peekByte = 9'h0;
    repeat (20) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    for (m = 0; m < 2; m++) begin
      binaryPages = m[0];
      sh = m ? 8 : 9;
      sz = m ? 256 : 264;
      ix = sz - 2;
      pg = 16 + int'(xs() % 240);
      sp = (m ? 384 : 256) + int'(xs() % 128);
      for (i = 0; i < 4; i++) begin
        rng = xs();
        b[i] = rng[7:0];
        dataQ.push_back(b[i]);
      end
      // start two bytes before the end so the load wraps
      cmd(`SFPE_OP_LOAD, ix, 4, 0);
      cmd(`SFPE_OP_PAGE_ERASE, pg << sh, 0, `SFPE_PAGE_ERASE_TIME_US * K);
      pk(pg, 7, 8'hff);
      cmd(`SFPE_OP_PGM_NOERASE, pg << sh, 0, `SFPE_PROGRAM_TIME_US * K);
      for (i = 0; i < 4; i++) pk(pg, (ix + i) % sz, b[i]);
      cmd(`SFPE_OP_PGM_ERASE, (pg ^ 1) << sh, 0, 2 * `SFPE_ERASE_PROGRAM_TIME_US * K);
      pk(pg ^ 1, 1, b[3]);
      // low page bits set: they must be ignored
      cmd(`SFPE_OP_BLOCK_ERASE, pg << sh, 0, `SFPE_BLOCK_ERASE_TIME_US * K);
      pk(pg ^ 1, 1, 8'hff);
      pk(pg, ix, 8'hff);
      cmd(`SFPE_OP_PGM_ERASE, sp << sh, 0, 2 * `SFPE_ERASE_PROGRAM_TIME_US * K);
      pk(sp, ix, b[0]);
      cmd(`SFPE_OP_SECTOR_ERASE, (sp ^ 42) << sh, 0, `SFPE_SECTOR_ERASE_TIME_US * K);
      pk(sp, ix, 8'hff);
    end
    results();
  end
endmodule
`default_nettype wire

// ==== verif/sfpe_link_asserts.sv ====
// checker: framing and busy timing on the link
// assumes instantiation beside the link interface
`timescale 1ns/100ps
`default_nettype none
module sfpe_link_asserts (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic chipSelectN,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic busy
);
  // bound is erase-program at twice its nominal count plus 16 cycles; sector erase is the longest nominal operation
  localparam int BUSY_MAX = 10016;
  int bitCnt_q;
  int csHigh_q;
  int busyCnt_q;
  logic sck_q;
  logic cs_q;
  // ====
  // helper counters
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      sck_q <= serialClk;
      cs_q <= chipSelectN;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) bitCnt_q <= 0;
    else if (cs_q && !chipSelectN) bitCnt_q <= 0;
    else if (serialClk && !sck_q) bitCnt_q <= bitCnt_q + 1;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) csHigh_q <= 0;
    else if (!chipSelectN) csHigh_q <= 0;
    else if (csHigh_q < 100) csHigh_q <= csHigh_q + 1;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) busyCnt_q <= 0;
    else busyCnt_q <= busy ? busyCnt_q + 1 : 0;
  end
  // ====
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence sckPulse;
    serialClk [*6] ##1 !serialClk;
  endsequence
  sequence busyStart;
    $rose(busy);
  endsequence
  a_sck_idle_low: assert property (chipSelectN |-> !serialClk)
    else $error("link clock moves outside a frame");
  a_sck_half_period: assert property ($rose(serialClk) |-> sckPulse)
    else $error("link clock high phase not six cycles");
  a_si_stable_high: assert property (serialClk && $past(serialClk) |-> $stable(serialIn))
    else $error("serial input moved while clock high");
  a_frame_whole_bytes: assert property ($rose(chipSelectN) |-> bitCnt_q >= 32 && bitCnt_q % 8 == 0)
    else $error("frame not whole bytes after address");
  a_busy_full_frame: assert property (busyStart |-> bitCnt_q >= 32)
    else $error("busy after a short frame");
  a_busy_prompt: assert property (busyStart |-> csHigh_q >= 1 && csHigh_q <= 10)
    else $error("busy not prompt after deselect");
  a_busy_holds_cs: assert property (busy |-> chipSelectN)
    else $error("frame started while busy");
  a_busy_bounded: assert property (busy |-> busyCnt_q <= BUSY_MAX)
    else $error("busy longer than any operation");
endmodule
`default_nettype wire
